// *** logic/aie_pkg.sv ***
// constants and types of the addition execute unit
package aie_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INSTR = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_INDEX = 8'h14;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EXT_BIT = 0;
  localparam int ST_C_BIT = 0;
  localparam int ST_DIGIT_CARRY_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_OVERFLOW_BIT = 3;
  localparam int ST_N_BIT = 4;
  localparam int ST_BUSY_BIT = 8;
  localparam int ST_ILL_BIT = 9;
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  // ----------------------------------------------------------------
  // opcodes and addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_ADD_LITERAL = 8'h0f;
  localparam logic [5:0] OPC_ADD_ACC_TO_REG = 6'h09;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;
  localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
  // ----------------------------------------------------------------
  // reset values and bus codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [11:0] INDEX_RESET = 12'h000;
  localparam logic [15:0] INSTR_RESET = 16'h0000;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;
  // idle plus one state per phase of the four-phase instruction cycle
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DECODE = 5'b00010,
    ST_READ = 5'b00100,
    ST_PROC = 5'b01000,
    ST_WRITE = 5'b10000
  } aie_state_t;
endpackage

// *** logic/aie_alu_if.sv ***
// operand and result bundle between core sequencer and adder
`timescale 1ns/100ps
`default_nettype none
interface aie_alu_if;
  logic [7:0] opA;
  logic [7:0] opB;
  logic [7:0] sum;
  logic carry;
  logic digitCarry;
  logic zero;
  logic overflow;
  logic negative;
  modport core (output opA, opB,
    input sum, carry, digitCarry, zero, overflow, negative);
  modport alu (input opA, opB,
    output sum, carry, digitCarry, zero, overflow, negative);
endinterface
`default_nettype wire

// *** logic/aie_alu.sv ***
// 8-bit adder with status flag generation
`timescale 1ns/100ps
`default_nettype none
module aie_alu (
  aie_alu_if.alu bus // operands in, sum and flags out
);
  import aie_pkg::*;
  logic [8:0] wide;
  logic [4:0] lowNib;
  assign wide = {1'b0, bus.opA} + {1'b0, bus.opB};
  assign lowNib = {1'b0, bus.opA[3:0]} + {1'b0, bus.opB[3:0]};
  assign bus.sum = wide[7:0];
  assign bus.carry = wide[8]; // RULE8
  assign bus.digitCarry = lowNib[4]; // RULE8
  assign bus.zero = (wide[7:0] == 8'h00); // RULE8
  assign bus.negative = wide[7]; // RULE8
  // signed overflow: like-signed operands giving an opposite sign
  assign bus.overflow = (bus.opA[7] == bus.opB[7]) &&
    (wide[7] != bus.opA[7]); // RULE8
endmodule // aie_alu
`default_nettype wire

// *** logic/aie_add_exec.sv ***
// addition instruction decode and execute unit with AHB-Lite registers
//
// Notes on behaviour
// RULE1 - literal add: accumulator plus immediate into accumulator
// RULE2 - register add: accumulator plus addressed data register
// RULE3 - destination bit clear: sum to accumulator
// RULE4 - destination bit set: sum to data register
// RULE5 - access bit clear: address in shared access bank
// RULE6 - access bit set: bank register picks bank
// RULE7 - extended, access clear, f<=95: indexed offset addressing
// RULE8 - both adds update all five status flags
// RULE9 - one word; decode, read, compute, write phases
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module aie_add_exec (
  input wire logic clk, // core clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  output logic [11:0] dmAddr, // data memory address
  output logic dmRdEn, // data memory read strobe
  output logic dmWrEn, // data memory write strobe
  output logic [7:0] dmWdata, // data memory write data
  input wire logic [7:0] dmRdata, // read data, cycle after dmRdEn
  output logic busy // instruction in progress
);
  import aie_pkg::*;

  aie_state_t state, next_state;
  logic [7:0] acc;
  logic [3:0] bankSelectReg;
  logic [11:0] indexBase;
  logic [15:0] instrWord;
  logic [4:0] flags;
  logic extEnable, illegal;
  logic wrPend;
  logic [7:0] wrAddr;
  aie_alu_if aluBus ();

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic acceptCycle;
  logic wrCtrl, wrInstr, wrAcc, wrBank, wrStatus, wrIndex;
  logic idle;
  assign acceptCycle = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign idle = (state == ST_IDLE);
  assign wrCtrl = wrPend && (wrAddr == REG_CTRL);
  assign wrInstr = wrPend && (wrAddr == REG_INSTR);
  assign wrAcc = wrPend && (wrAddr == REG_ACC);
  assign wrBank = wrPend && (wrAddr == REG_BANK);
  assign wrStatus = wrPend && (wrAddr == REG_STATUS);
  assign wrIndex = wrPend && (wrAddr == REG_INDEX);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= acceptCycle && hwrite && (hsize == HSIZE_WORD);
      wrAddr <= haddr;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b0;
      hresp <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (haddr)
      REG_CTRL: next_rdata[CTRL_EXT_BIT] = extEnable;
      REG_INSTR: next_rdata[15:0] = instrWord;
      REG_ACC: next_rdata[7:0] = acc;
      REG_BANK: next_rdata[3:0] = bankSelectReg;
      REG_STATUS: begin
        next_rdata[4:0] = flags;
        next_rdata[ST_BUSY_BIT] = !idle;
        next_rdata[ST_ILL_BIT] = illegal;
      end
      REG_INDEX: next_rdata[11:0] = indexBase;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acceptCycle && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      extEnable <= 1'b0;
      bankSelectReg <= BANK_RESET;
      indexBase <= INDEX_RESET;
    end else begin
      if (wrCtrl) extEnable <= hwdata[CTRL_EXT_BIT];
      if (wrBank) bankSelectReg <= hwdata[3:0];
      if (wrIndex) indexBase <= hwdata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic isLit, isReg, legalWord, destBit, accessBit, indexed;
  logic [7:0] fileAddr;
  logic [11:0] opAddr;
  assign isLit = (instrWord[15:8] == OPC_ADD_LITERAL); // RULE1
  assign isReg = (instrWord[15:10] == OPC_ADD_ACC_TO_REG); // RULE2
  assign legalWord = (hwdata[15:8] == OPC_ADD_LITERAL) ||
    (hwdata[15:10] == OPC_ADD_ACC_TO_REG);
  assign destBit = instrWord[DEST_BIT];
  assign accessBit = instrWord[ACCESS_BIT];
  assign fileAddr = instrWord[7:0];
  assign indexed = extEnable && !accessBit &&
    (fileAddr <= INDEXED_LIMIT); // RULE7

  always_comb begin
    if (accessBit) begin
      opAddr = {bankSelectReg, fileAddr}; // RULE6
    end else if (indexed) begin
      opAddr = indexBase + {4'h0, fileAddr}; // RULE7
    end else if (fileAddr >= ACCESS_SPLIT) begin
      opAddr = {ACCESS_HIGH_PAGE, fileAddr}; // RULE5
    end else begin
      opAddr = {ACCESS_LOW_PAGE, fileAddr}; // RULE5
    end
  end

  // instruction word is only taken while no instruction runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      instrWord <= INSTR_RESET;
    end else if (wrInstr && idle) begin
      instrWord <= hwdata[15:0];
    end
  end

  // set by an unknown opcode wins over a write-one clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      illegal <= 1'b0;
    end else if (wrInstr && idle && !legalWord) begin
      illegal <= 1'b1;
    end else if (wrStatus && hwdata[ST_ILL_BIT]) begin
      illegal <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // four-phase sequencer
  // ----------------------------------------------------------------
  always_comb begin
    unique case (state)
      ST_IDLE: next_state = (wrInstr && legalWord) ? ST_DECODE : ST_IDLE;
      ST_DECODE: next_state = ST_READ; // RULE9
      ST_READ: next_state = ST_PROC; // RULE9
      ST_PROC: next_state = ST_WRITE; // RULE9
      ST_WRITE: next_state = ST_IDLE; // RULE9
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      busy <= (next_state != ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // operand read, compute and write-back
  // ----------------------------------------------------------------
  assign aluBus.opA = acc;
  assign aluBus.opB = isLit ? fileAddr : dmRdata; // RULE1 RULE2
  aie_alu aie_alu_inst (
    .bus(aluBus)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dmAddr <= 12'h000;
      dmRdEn <= 1'b0;
    end else begin
      if (state == ST_DECODE) dmAddr <= opAddr; // RULE5 RULE6 RULE7
      dmRdEn <= (state == ST_DECODE) && isReg; // RULE2
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dmWrEn <= 1'b0;
      dmWdata <= 8'h00;
    end else begin
      dmWrEn <= (state == ST_PROC) && isReg && destBit; // RULE4
      if (state == ST_PROC) dmWdata <= aluBus.sum;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc <= ACC_RESET;
    end else if (state == ST_PROC && (isLit || !destBit)) begin
      acc <= aluBus.sum; // RULE1 RULE3
    end else if (wrAcc && idle) begin
      acc <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags <= FLAGS_RESET;
    end else if (state == ST_PROC) begin
      flags[ST_C_BIT] <= aluBus.carry; // RULE8
      flags[ST_DIGIT_CARRY_BIT] <= aluBus.digitCarry; // RULE8
      flags[ST_Z_BIT] <= aluBus.zero; // RULE8
      flags[ST_OVERFLOW_BIT] <= aluBus.overflow; // RULE8
      flags[ST_N_BIT] <= aluBus.negative; // RULE8
    end else if (wrStatus && idle) begin
      flags <= hwdata[4:0];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [7:0] chkSum;
  assign chkSum = acc + (isLit ? fileAddr : dmRdata);

  AST_LIT_SUM: assert property (@(posedge clk) disable iff (!resetn) // RULE1
    (state == ST_PROC && isLit) |=> (acc == $past(chkSum)))
    else $error("literal add result wrong");
  AST_REG_READ: assert property (@(posedge clk) disable iff (!resetn) // RULE2
    (state == ST_DECODE && isReg) |=> (dmRdEn && state == ST_READ))
    else $error("operand read strobe missing");
  AST_DEST_ACC: assert property (@(posedge clk) disable iff (!resetn) // RULE3
    (state == ST_PROC && isReg && !destBit) |=>
    (!dmWrEn && acc == $past(chkSum)))
    else $error("accumulator destination wrong");
  AST_DEST_REG: assert property (@(posedge clk) disable iff (!resetn) // RULE4
    (state == ST_PROC && isReg && destBit) |=>
    (dmWrEn && dmWdata == $past(chkSum) && $stable(acc)))
    else $error("register destination wrong");
  AST_ACCESS: assert property (@(posedge clk) disable iff (!resetn) // RULE5
    (state == ST_DECODE && !accessBit && !indexed) |=>
    (dmAddr[7:0] == fileAddr && dmAddr[11:8] == ((fileAddr >= ACCESS_SPLIT)
    ? ACCESS_HIGH_PAGE : ACCESS_LOW_PAGE)))
    else $error("access bank address wrong");
  AST_BANK: assert property (@(posedge clk) disable iff (!resetn) // RULE6
    (state == ST_DECODE && accessBit) |=>
    (dmAddr == {$past(bankSelectReg), fileAddr}))
    else $error("banked address wrong");
  AST_INDEXED: assert property (@(posedge clk) disable iff (!resetn) // RULE7
    (state == ST_DECODE && extEnable && !accessBit &&
    fileAddr <= INDEXED_LIMIT) |=>
    (dmAddr == 12'($past(indexBase) + {4'h0, fileAddr})))
    else $error("indexed address wrong");
  AST_FLAGS: assert property (@(posedge clk) disable iff (!resetn) // RULE8
    (state == ST_PROC) |=> (flags[ST_Z_BIT] == ($past(chkSum) == 8'h00) &&
    flags[ST_N_BIT] == $past(chkSum[7])))
    else $error("zero or negative flag wrong");
  AST_PHASES: assert property (@(posedge clk) disable iff (!resetn) // RULE9
    (state == ST_DECODE) |=> (state == ST_READ) ##1 (state == ST_PROC)
    ##1 (state == ST_WRITE) ##1 (state == ST_IDLE))
    else $error("phase sequence broken");
endmodule // aie_add_exec
`default_nettype wire

// *** test/aie_dmem_model.sv ***
// data memory model answering the execute unit's operand port
`timescale 1ns/100ps
`default_nettype none
module aie_dmem_model (
  input wire logic clk, // core clock
  input wire logic [11:0] dmAddr, // operand address
  input wire logic dmRdEn, // read strobe
  input wire logic dmWrEn, // write strobe
  input wire logic [7:0] dmWdata, // write data
  output logic [7:0] dmRdata // read data, cycle after strobe
);
  logic [7:0] mem [0:4095];
  logic [7:0] lastData;
  logic rdValid;
  initial begin
    rdValid = 1'b0;
    lastData = 8'h00;
  end
  // outside the answer cycle the line never shows the stale value
  assign dmRdata = rdValid ? lastData : ~lastData;
  always @(posedge clk) begin
    rdValid <= dmRdEn;
    if (dmRdEn) begin
      lastData <= mem[dmAddr];
    end
    if (dmWrEn) begin
      mem[dmAddr] <= dmWdata;
    end
  end
endmodule // aie_dmem_model
`default_nettype wire

// *** test/aie_add_exec_bench.sv ***
// self-checking bench of the addition execute unit
`timescale 1ns/100ps
`default_nettype none
module aie_add_exec_bench;
  import aie_pkg::*;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, dmRdEn, dmWrEn, busy;
  logic [7:0] haddr, dmWdata, dmRdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic [11:0] dmAddr;
  int err_total, compares;
  aie_add_exec aie_add_exec_inst (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dmAddr(dmAddr),
    .dmRdEn(dmRdEn), .dmWrEn(dmWrEn), .dmWdata(dmWdata),
    .dmRdata(dmRdata), .busy(busy));
  aie_dmem_model aie_dmem_model_inst (.clk(clk), .dmAddr(dmAddr),
    .dmRdEn(dmRdEn), .dmWrEn(dmWrEn), .dmWdata(dmWdata),
    .dmRdata(dmRdata));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w,
    input logic [31:0] wd, output logic [31:0] rd);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsize <= HSIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(a, 1'b0, 32'h0, x);
    chk(x, exp);
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask
  function automatic logic [4:0] flags_of(input logic [7:0] a,
    input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
      h[4], s[8]};
  endfunction
  // runs one add word and checks accumulator, flags and memory
  task automatic run_add(input logic [15:0] ins, input logic [7:0] acc0,
    input logic [11:0] ma, input logic [7:0] m0);
    int n;
    logic lit, toMem;
    logic [7:0] b, s;
    lit = (ins[15:8] == OPC_ADD_LITERAL);
    toMem = !lit && ins[DEST_BIT];
    b = lit ? ins[7:0] : m0;
    s = acc0 + b;
    aie_dmem_model_inst.mem[ma] = m0;
    wr(REG_ACC, {24'h0, acc0});
    wr(REG_INSTR, {16'h0, ins});
    n = 0;
    #1;
    while (busy === 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, 32'd4);
    @(posedge clk);
    rd_chk(REG_ACC, {24'h0, toMem ? acc0 : s});
    rd_chk(REG_STATUS, {27'h0, flags_of(acc0, b)});
    chk({24'h0, aie_dmem_model_inst.mem[ma]}, {24'h0, toMem ? s : m0});
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_literal;
    logic [15:0] tab [5] = '{16'h1015, 16'h8080, 16'h0808, 16'h7f01,
      16'hff01};
    foreach (tab[i]) begin
      run_add({OPC_ADD_LITERAL, tab[i][7:0]}, tab[i][15:8], 12'h0, 8'h0);
    end
    $display("test_literal done");
  endtask
  task automatic test_access;
    wr(REG_CTRL, 32'h0);
    run_add(16'h2420, 8'h17, 12'h020, 8'hc2);
    run_add(16'h2690, 8'h01, 12'hf90, 8'h7f);
    $display("test_access done");
  endtask
  task automatic test_banked;
    wr(REG_BANK, 32'h5);
    rd_chk(REG_BANK, 32'h5);
    run_add(16'h2733, 8'h40, 12'h533, 8'h40);
    run_add(16'h25f0, 8'h90, 12'h5f0, 8'h90);
    $display("test_banked done");
  endtask
  task automatic test_indexed;
    wr(REG_CTRL, 32'h1);
    wr(REG_INDEX, 32'h123);
    rd_chk(REG_INDEX, 32'h123);
    rd_chk(REG_CTRL, 32'h1);
    run_add(16'h265f, 8'h02, 12'h182, 8'h11);
    run_add(16'h2660, 8'h02, 12'h060, 8'h11);
    wr(REG_CTRL, 32'h0);
    rd_chk(8'h18, 32'h0);
    $display("test_indexed done");
  endtask
  // unknown word, writes while busy, busy and status readback
  task automatic test_refused;
    wr(REG_STATUS, 32'h0);
    wr(REG_INSTR, 32'h1234);
    rd_chk(REG_STATUS, 32'h200);
    chk({31'h0, busy}, 32'h0);
    wr(REG_STATUS, 32'h21f);
    rd_chk(REG_STATUS, 32'h1f);
    wr(REG_ACC, 32'h10);
    wr(REG_INSTR, 32'h0f05);
    wr(REG_INSTR, 32'h0f01);
    rd_chk(REG_STATUS, 32'h11f);
    wr(REG_INSTR, 32'h0f07);
    wr(REG_ACC, 32'h77);
    repeat (3) @(posedge clk);
    rd_chk(REG_ACC, 32'h1c);
    rd_chk(REG_INSTR, 32'h0f07);
    $display("test_refused done");
  endtask
  // ----------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    err_total = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    test_literal();
    test_access();
    test_banked();
    test_indexed();
    test_refused();
    give_verdict();
  end
  initial begin
    #2000000;
    err_total++;
    give_verdict();
  end
endmodule // aie_add_exec_bench
`default_nettype wire
